// ==== rtl/css_status.sv ====
module css_status
  import css_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // converter events, same clock domain
  input wire css_evt_s evt,
  input wire logic output_powered,
  // pin from outside
  input wire logic power_ready_pin,
  // host command port
  input wire css_req_s req,
  input wire logic wr,
  input wire logic [7:0] wr_cmd,
  // answers
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic host_alert_pin
);

  // ------------------------------------------------------------
  // reset release and pin synchronisation
  // ------------------------------------------------------------
  logic rst_meta_ff;
  logic rst_sync_ff;
  logic ready_s;

  // reset enters asynchronously, is released on the clock
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  css_sync u_ready_sync (
    .clk(ref_clk),
    .rst_n(rst_sync_ff),
    .d(power_ready_pin),
    .q(ready_s)
  );

  // ------------------------------------------------------------
  // latched flags and raw status bits
  // ------------------------------------------------------------
  logic clr;
  logic ov_ff, oc_ff, uv_ff, temp_ff, comm_ff, other_ff;
  logic volt_grp_ff, curr_grp_ff, input_grp_ff, vendor_ff;
  logic vovf_ff, vuvf_ff, vmaxw_ff;
  logic off_ff, notrdy_ff;
  logic other_set;
  logic uv_only_ff;

  // writes other than clear-faults never reach any flag
  assign clr = wr && (wr_cmd == CSS_CMD_CLEAR_FAULTS);
  assign other_set = evt.uv_fault | evt.oc_warn | evt.vin_other | evt.max_warn | evt.vendor_fault;

  // summary byte flags; a set in the clear cycle wins
  always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      ov_ff <= 1'b0;
      oc_ff <= 1'b0;
      uv_ff <= 1'b0;
      temp_ff <= 1'b0;
      comm_ff <= 1'b0;
      other_ff <= 1'b0;
    end else begin
      ov_ff <= evt.ov_fault | (ov_ff & ~clr);
      oc_ff <= evt.oc_fault | (oc_ff & ~clr);
      uv_ff <= evt.vin_lockout | (uv_ff & ~clr);
      temp_ff <= evt.temp_event | (temp_ff & ~clr);
      comm_ff <= evt.comm_memory_logic_fault | (comm_ff & ~clr);
      other_ff <= other_set | (other_ff & ~clr);
    end
  end

  // upper byte group flags
  always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      volt_grp_ff <= 1'b0;
      curr_grp_ff <= 1'b0;
      input_grp_ff <= 1'b0;
      vendor_ff <= 1'b0;
    end else begin
      volt_grp_ff <= evt.ov_fault | evt.uv_fault | evt.max_warn | (volt_grp_ff & ~clr);
      curr_grp_ff <= evt.oc_fault | evt.oc_warn | (curr_grp_ff & ~clr);
      input_grp_ff <= evt.vin_lockout | evt.vin_other | (input_grp_ff & ~clr);
      vendor_ff <= evt.vendor_fault | (vendor_ff & ~clr);
    end
  end

  // output voltage flag byte
  always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      vovf_ff <= 1'b0;
      vuvf_ff <= 1'b0;
      vmaxw_ff <= 1'b0;
    end else begin
      vovf_ff <= evt.ov_fault | (vovf_ff & ~clr);
      vuvf_ff <= evt.uv_fault | (vuvf_ff & ~clr);
      vmaxw_ff <= evt.max_warn | (vmaxw_ff & ~clr);
    end
  end

  // raw status, refreshed every cycle, never latched
  always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      off_ff <= 1'b0;
      notrdy_ff <= 1'b0;
    end else begin
      off_ff <= ~output_powered;
      notrdy_ff <= ~ready_s;
    end
  end

  // ------------------------------------------------------------
  // register images
  // ------------------------------------------------------------
  logic [7:0] summary;
  logic [15:0] word_img;
  logic [7:0] volt_img;

  // one summary image feeds both the byte and word reads
  always_comb begin
    summary = 8'h00;
    summary[CSS_B_BUSY] = 1'b0;
    summary[CSS_B_OFF] = off_ff;
    summary[CSS_B_OV] = ov_ff;
    summary[CSS_B_OC] = oc_ff;
    summary[CSS_B_UV] = uv_ff;
    summary[CSS_B_TEMP] = temp_ff;
    summary[CSS_B_COMM] = comm_ff;
    summary[CSS_B_OTHER] = other_ff;
    word_img = CSS_WORD_RESET; // bits 10..8 stay zero
    word_img[7:0] = summary;
    word_img[CSS_W_VGRP] = volt_grp_ff;
    word_img[CSS_W_IGRP] = curr_grp_ff;
    word_img[CSS_W_INPUT] = input_grp_ff;
    word_img[CSS_W_VENDOR] = vendor_ff;
    word_img[CSS_W_NOTRDY] = notrdy_ff;
    volt_img = CSS_VOLT_RESET;
    volt_img[CSS_V_OVF] = vovf_ff;
    volt_img[CSS_V_UVF] = vuvf_ff;
    volt_img[CSS_V_MAXW] = vmaxw_ff;
  end

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  // unmapped commands answer with zero data and a valid strobe
  always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      rd_data <= CSS_WORD_RESET;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= req.rd;
      if (req.rd) begin
        unique case (req.cmd)
          CSS_CMD_SUMMARY_BYTE: rd_data <= {8'h00, summary};
          CSS_CMD_SUMMARY_WORD: rd_data <= word_img;
          CSS_CMD_VOLT_FLAGS: rd_data <= {8'h00, volt_img};
          default: rd_data <= 16'h0000;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // alert
  // ------------------------------------------------------------
  // alert follows the latches, so it drops only on clear-faults
  always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      host_alert_pin <= 1'b0;
    end else begin
      host_alert_pin <= ov_ff | oc_ff | temp_ff | comm_ff | other_ff | vendor_ff |
                        curr_grp_ff | volt_grp_ff | (input_grp_ff & ~uv_only_ff);
    end
  end

  // tracks whether the input group was raised by undervoltage alone
  always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      uv_only_ff <= 1'b1;
    end else if (evt.vin_other) begin
      uv_only_ff <= 1'b0;
    end else if (clr) begin
      uv_only_ff <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_ov_evt;
    evt.ov_fault;
  endsequence

  // two quiet cycles with no clear after an event
  sequence s_no_clr;
    (!clr) [*2];
  endsequence

  // a read request of the full word
  sequence s_rd_word;
    req.rd && req.cmd == CSS_CMD_SUMMARY_WORD;
  endsequence

  // a read request of the voltage flag byte
  sequence s_rd_volt;
    req.rd && req.cmd == CSS_CMD_VOLT_FLAGS;
  endsequence

  // ------------------------------------------------------------
  // latch checks
  // ------------------------------------------------------------
  // overvoltage stays up while nobody clears it
  AST_OV_LATCH: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
    s_ov_evt ##1 s_no_clr |-> ov_ff && $past(ov_ff)) else $error("ov flag not latched");

  // overcurrent sets its summary bit and its group bit
  AST_OC_LATCH: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
    evt.oc_fault |=> oc_ff && curr_grp_ff) else $error("oc flag not set");

  // input lockout sets the summary bit and the input group
  AST_UV_LATCH: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
    evt.vin_lockout |=> uv_ff && input_grp_ff)
    else $error("lockout flag not set");

  // temperature fault or warning share one flag
  AST_TEMP_LATCH: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
    evt.temp_event |=> temp_ff)
    else $error("temperature flag not set");

  // comm, memory or logic fault
  AST_COMM_LATCH: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
    evt.comm_memory_logic_fault |=> comm_ff)
    else $error("comm flag not set");

  // anything without a bit of its own lands in bit 0
  AST_OTHER_LATCH: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
    evt.oc_warn || evt.uv_fault |=> other_ff)
    else $error("other flag not set");

  // output undervoltage raises the voltage group and its own flag
  AST_VGRP_LATCH: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
    evt.uv_fault |=> volt_grp_ff && vuvf_ff)
    else $error("voltage group not set");

  // output current warning raises the current group
  AST_IGRP_LATCH: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
    evt.oc_warn |=> curr_grp_ff)
    else $error("current group not set");

  // vendor fault raises its bit and the other bit
  AST_VENDOR_LATCH: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
    evt.vendor_fault |=> vendor_ff && other_ff)
    else $error("vendor flag not set");

  // max-exceeded warning
  AST_MAXW_LATCH: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
    evt.max_warn |=> vmaxw_ff)
    else $error("max warning not set");

  // clear-faults drops the flags that no event refreshes
  AST_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
    clr && !other_set && !evt.comm_memory_logic_fault |=> !other_ff && !comm_ff) else $error("clear failed");

  // an event in the clear cycle must survive
  AST_SET_WINS: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
    clr && evt.max_warn |=> vmaxw_ff && volt_grp_ff) else $error("set lost to clear");

  // no clear, no drop
  AST_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
    comm_ff && !clr |=> comm_ff)
    else $error("flag dropped without clear");

  // other write codes leave the flags alone
  AST_WRITE_IGNORED: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
    wr && wr_cmd != CSS_CMD_CLEAR_FAULTS && ov_ff |=> ov_ff)
    else $error("write touched a flag");

  // ------------------------------------------------------------
  // read checks
  // ------------------------------------------------------------
  // busy and unsupported word bits read zero; the voltage byte owns bit 7
  AST_ZERO_BITS: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
    rd_valid && $past(req.cmd) != CSS_CMD_VOLT_FLAGS |-> rd_data[10:7] == 4'h0) else $error("reserved bits nonzero");

  // byte and low word byte come from one image
  AST_SAME_BYTE: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
    req.rd && req.cmd == CSS_CMD_SUMMARY_BYTE |=> rd_valid && rd_data[7:0] == $past(word_img[7:0]))
    else $error("byte differs from word");

  // word read returns the whole image one cycle later
  AST_WORD_READ: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
    s_rd_word |=> rd_valid && rd_data == $past(word_img))
    else $error("word read wrong");

  // voltage byte has only its three supported bits
  AST_VOLT_READ: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
    s_rd_volt |=> rd_data[15:8] == 8'h00 && rd_data[6:5] == 2'b00 && rd_data[2:0] == 3'b000)
    else $error("voltage byte unsupported bits set");

  // no answer without a request
  AST_NO_SPURIOUS: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
    !req.rd |=> !rd_valid)
    else $error("answer without request");

  // ------------------------------------------------------------
  // alert and raw status checks
  // ------------------------------------------------------------
  // lockout alone never alerts
  AST_UV_NO_ALERT: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
    (word_img == 16'h2008) && uv_only_ff |=> !host_alert_pin) else $error("lockout raised alert");

  // a temperature event alerts two cycles on
  AST_ALERT_TEMP: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
    evt.temp_event |-> ##2 host_alert_pin) else $error("alert missing");

  // the off bit follows the level, it is not held
  AST_OFF_RAW: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
    !output_powered ##1 output_powered |=> !off_ff) else $error("off bit latched");

  // skip the first live edge, where the flop still holds its reset value
  AST_NOT_READY: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
    $past(rst_sync_ff) && $past(ready_s) == ready_s |-> notrdy_ff == !ready_s) else $error("ready inverse wrong");
endmodule : css_status

// ==== rtl/css_pkg.sv ====
package css_pkg;
  // ------------------------------------------------------------
  // command codes
  // ------------------------------------------------------------
  localparam logic [7:0] CSS_CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CSS_CMD_SUMMARY_BYTE = 8'h78;
  localparam logic [7:0] CSS_CMD_SUMMARY_WORD = 8'h79;
  localparam logic [7:0] CSS_CMD_VOLT_FLAGS = 8'h7a;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [15:0] CSS_WORD_RESET = 16'h0000;
  localparam logic [7:0] CSS_VOLT_RESET = 8'h00;

  // ------------------------------------------------------------
  // summary byte bit positions
  // ------------------------------------------------------------
  localparam int CSS_B_BUSY = 7;
  localparam int CSS_B_OFF = 6;
  localparam int CSS_B_OV = 5;
  localparam int CSS_B_OC = 4;
  localparam int CSS_B_UV = 3;
  localparam int CSS_B_TEMP = 2;
  localparam int CSS_B_COMM = 1;
  localparam int CSS_B_OTHER = 0;
  // upper byte of the status word
  localparam int CSS_W_VGRP = 15;
  localparam int CSS_W_IGRP = 14;
  localparam int CSS_W_INPUT = 13;
  localparam int CSS_W_VENDOR = 12;
  localparam int CSS_W_NOTRDY = 11;
  // output voltage flags
  localparam int CSS_V_OVF = 7;
  localparam int CSS_V_UVF = 4;
  localparam int CSS_V_MAXW = 3;

  // ------------------------------------------------------------
  // event carrier: one-cycle pulses from the converter logic
  // ------------------------------------------------------------
  typedef struct packed {
    logic ov_fault;
    logic uv_fault;
    logic max_warn;
    logic oc_fault;
    logic oc_warn;
    logic vin_lockout;
    logic vin_other;
    logic temp_event;
    logic comm_memory_logic_fault;
    logic vendor_fault;
  } css_evt_s;

  // host read request
  typedef struct packed {
    logic rd;
    logic [7:0] cmd;
  } css_req_s;
endpackage : css_pkg

// ==== rtl/css_sync.sv ====
module css_sync
  import css_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // level crossing
  input wire logic d,
  output logic q
);
  logic meta_ff;

  // two-stage synchroniser; only the second stage is read outside
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule : css_sync

// ==== testbench/css_host_model.sv ====
module css_host_model
  import css_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // host command lines
  output css_req_s req,
  output logic wr,
  output logic [7:0] wr_cmd
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle lines from time zero
  initial begin
    req = '0;
    wr = 1'b0;
    wr_cmd = 8'h00;
  end

  // one-cycle read strobe; the code flips once released so nothing stale lingers
  task automatic read_cmd(input logic [7:0] cmd);
    @(negedge ref_clk);
    req <= {1'b1, cmd};
    @(negedge ref_clk);
    req <= {1'b0, ~cmd};
  endtask : read_cmd

  // one-cycle write strobe; only the clear code should act
  task automatic write_cmd(input logic [7:0] cmd);
    @(negedge ref_clk);
    wr <= 1'b1;
    wr_cmd <= cmd;
    @(negedge ref_clk);
    wr <= 1'b0;
    wr_cmd <= ~cmd;
  endtask : write_cmd
endmodule : css_host_model

// ==== testbench/converter_status_summary_bench.sv ====
module converter_status_summary_bench;
  import css_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // signals and expected images
  // ----------------------------------------
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  css_evt_s evt = '0;
  logic output_powered = 1'b0;
  logic power_ready_pin = 1'b1;
  css_req_s req;
  logic wr;
  logic [7:0] wr_cmd;
  logic [15:0] rd_data;
  logic rd_valid;
  logic host_alert_pin;
  int errors = 0;
  int checks = 0;
  logic [15:0] exp_q[$];
  logic [31:0] rng = 32'h0000_0055;
  logic [15:0] e;
  logic [9:0] m;
  // word image per event, indexed by evt bit (0 is the vendor fault)
  logic [15:0] word_tab [10] = '{16'h1001, 16'h0002, 16'h0004, 16'h2001, 16'h2008,
                                 16'h4001, 16'h4010, 16'h8001, 16'h8001, 16'h8020};
  logic [7:0] volt_tab [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h10, 8'h80};

  always #12.5 ref_clk = ~ref_clk;

  css_status i_dut(.ref_clk(ref_clk), .rst_n(rst_n), .evt(evt), .output_powered(output_powered),
    .power_ready_pin(power_ready_pin), .req(req), .wr(wr), .wr_cmd(wr_cmd), .rd_data(rd_data),
    .rd_valid(rd_valid), .host_alert_pin(host_alert_pin));
  css_host_model i_host(.ref_clk(ref_clk), .req(req), .wr(wr), .wr_cmd(wr_cmd));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // note the expected answer first, then let the host ask
  task automatic rd_exp(input logic [7:0] cmd, input logic [15:0] exp);
    exp_q.push_back(exp);
    i_host.read_cmd(cmd);
  endtask : rd_exp

  // bounded wait for every noted read to come back
  task automatic drain();
    int n = 0;
    while (exp_q.size() > 0 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    if (exp_q.size() > 0) begin
      errors++;
      $display("BAD drain expected 0 seen %0d", exp_q.size());
      end_of_test();
    end
  endtask : drain

  task automatic pulse(input logic [9:0] msk);
    @(negedge ref_clk);
    evt <= msk;
    @(negedge ref_clk);
    evt <= '0;
    repeat (2) @(negedge ref_clk);
  endtask : pulse

  // clear, then give flags and alert their two cycles to drop
  task automatic clear();
    i_host.write_cmd(CSS_CMD_CLEAR_FAULTS);
    repeat (2) @(negedge ref_clk);
  endtask : clear

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  // watcher: valid stands one cycle, so look mid-cycle while it is high
  always @(negedge ref_clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        errors++;
        $display("BAD read_data expected none seen %h", rd_data);
      end else check("read_data", exp_q.pop_front(), rd_data);
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (6) @(negedge ref_clk);
    rd_exp(CSS_CMD_SUMMARY_WORD, 16'h0040);
    rd_exp(CSS_CMD_VOLT_FLAGS, 16'h0000);
    rd_exp(8'h55, 16'h0000);
    drain();
    check("alert", 16'h0000, {15'h0000, host_alert_pin});
    $display("test reset done");
    output_powered = 1'b1;
    repeat (2) @(negedge ref_clk);
    for (int i = 0; i < 10; i++) begin
      pulse(10'h001 << i);
      check("alert", {15'h0000, i != 4}, {15'h0000, host_alert_pin});
      rd_exp(CSS_CMD_SUMMARY_WORD, word_tab[i]);
      rd_exp(CSS_CMD_SUMMARY_BYTE, {8'h00, word_tab[i][7:0]});
      rd_exp(CSS_CMD_VOLT_FLAGS, {8'h00, volt_tab[i]});
      drain();
      clear();
      check("alert", 16'h0000, {15'h0000, host_alert_pin});
    end
    $display("test single events done");
    pulse(10'h204);
    repeat (8) @(negedge ref_clk);
    for (int k = 0; k < 4; k++) begin
      rng = xs(rng);
      i_host.write_cmd(rng[7:0] == 8'h03 ? 8'h04 : rng[7:0]);
    end
    rd_exp(CSS_CMD_SUMMARY_WORD, 16'h8024);
    drain();
    clear();
    rd_exp(CSS_CMD_SUMMARY_WORD, 16'h0000);
    drain();
    $display("test latch and writes done");
    output_powered = 1'b0;
    power_ready_pin = 1'b0;
    repeat (6) @(negedge ref_clk);
    rd_exp(CSS_CMD_SUMMARY_WORD, 16'h0840);
    drain();
    check("alert", 16'h0000, {15'h0000, host_alert_pin});
    output_powered = 1'b1;
    power_ready_pin = 1'b1;
    repeat (6) @(negedge ref_clk);
    rd_exp(CSS_CMD_SUMMARY_WORD, 16'h0000);
    drain();
    $display("test raw bits done");
    // max warning lands in the very cycle of a clear: the set must survive
    fork
      pulse(10'h080);
      i_host.write_cmd(CSS_CMD_CLEAR_FAULTS);
    join
    rd_exp(CSS_CMD_SUMMARY_WORD, 16'h8001);
    rd_exp(CSS_CMD_VOLT_FLAGS, 16'h0008);
    drain();
    clear();
    $display("test set over clear done");
    for (int k = 0; k < 6; k++) begin
      rng = xs(rng);
      m = rng[9:0];
      e = 16'h0000;
      for (int i = 0; i < 10; i++) if (m[i]) e |= word_tab[i];
      pulse(m);
      check("alert", {15'h0000, (m & 10'h3ef) != 0}, {15'h0000, host_alert_pin});
      rd_exp(CSS_CMD_SUMMARY_WORD, e);
      drain();
      clear();
    end
    $display("test random events done");
    end_of_test();
  end
endmodule : converter_status_summary_bench
